// >>> core/packet_core_ctrl_status_regs.sv
// Control and status register bank of the packet processing core
`timescale 1ns/1ps
`default_nettype none
module packet_core_ctrl_status_regs (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire packet_core_regs_pkg::reg_access_t i_access,
    input wire packet_core_regs_pkg::core_status_t i_status,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    output var packet_core_regs_pkg::core_ctrl_t o_ctrl
);
    logic [15:0] start_address;
    logic single_step;
    logic counter_enable;
    logic fetch_enable;
    logic soft_reset;
    logic [15:0] pc_view;
    logic [31:0] cycle_count;
    logic [31:0] stall_count;
    logic [31:0] rdata;
    logic rvalid;
    logic [15:0] next_start_address;
    logic next_single_step;
    logic next_counter_enable;
    logic next_fetch_enable;
    logic next_soft_reset;
    logic [15:0] next_pc_view;
    logic [31:0] next_cycle_count;
    logic [31:0] next_stall_count;
    logic [31:0] next_rdata;
    logic next_rvalid;
    logic wr_ctrl;
    logic wake_req;
    logic counting;

    // Register region selected only with the region request
    function automatic logic hit(input packet_core_regs_pkg::reg_access_t a, input logic [7:0] off);
        hit = a.req && a.regs_req && (a.addr == off);
    endfunction : hit

    // Assembled control word; reserved bits are constant zero
    function automatic logic [31:0] ctrl_word(input logic [15:0] sa, input logic run, input logic big,
                                              input logic stp, input logic cen, input logic sleep_flag,
                                              input logic fen, input logic srst);
        ctrl_word = 32'h0000_0000;
        ctrl_word[31:packet_core_regs_pkg::start_address_lsb] = sa;
        ctrl_word[packet_core_regs_pkg::running_bit] = run;
        ctrl_word[packet_core_regs_pkg::big_endian_bit] = big;
        ctrl_word[packet_core_regs_pkg::single_step_bit] = stp;
        ctrl_word[packet_core_regs_pkg::counter_enable_bit] = cen;
        ctrl_word[packet_core_regs_pkg::sleep_bit] = sleep_flag;
        ctrl_word[packet_core_regs_pkg::fetch_enable_bit] = fen;
        ctrl_word[packet_core_regs_pkg::soft_reset_bit] = srst;
    endfunction : ctrl_word

    assign wr_ctrl = hit(i_access, packet_core_regs_pkg::core_control_offset) && i_access.wr;
    // Counters measure the same enabled cycles, so stall never passes cycle
    assign counting = counter_enable && fetch_enable;

    // Next state of control fields
    always_comb begin
        next_start_address = start_address;
        next_single_step = single_step;
        next_counter_enable = counter_enable;
        next_fetch_enable = fetch_enable;
        next_soft_reset = 1'b1;
        wake_req = 1'b0;
        // Step mode drops fetch enable after one finished instruction
        if (single_step && fetch_enable && i_status.instr_done) begin
            next_fetch_enable = 1'b0;
        end
        if (wr_ctrl) begin
            next_start_address = i_access.wdata[31:packet_core_regs_pkg::start_address_lsb];
            next_single_step = i_access.wdata[packet_core_regs_pkg::single_step_bit];
            next_counter_enable = i_access.wdata[packet_core_regs_pkg::counter_enable_bit];
            next_fetch_enable = i_access.wdata[packet_core_regs_pkg::fetch_enable_bit];
            next_soft_reset = i_access.wdata[packet_core_regs_pkg::soft_reset_bit];
            wake_req = ~i_access.wdata[packet_core_regs_pkg::sleep_bit];
        end
    end

    // Next state of counters and pc view; write to read-only words ignored
    always_comb begin
        next_pc_view = i_status.pc;
        next_cycle_count = cycle_count;
        next_stall_count = stall_count;
        if (counting) begin
            next_cycle_count = cycle_count + 32'h0000_0001;
            if (i_status.stalled) begin
                next_stall_count = stall_count + 32'h0000_0001;
            end
        end
    end

    // Read data; unmapped offsets return zero
    always_comb begin
        next_rvalid = i_access.req && i_access.regs_req && !i_access.wr;
        next_rdata = 32'h0000_0000;
        if (hit(i_access, packet_core_regs_pkg::core_control_offset)) begin
            next_rdata = ctrl_word(start_address, i_status.running, i_status.big_endian, single_step,
                                   counter_enable, i_status.asleep, fetch_enable, soft_reset);
        end else if (hit(i_access, packet_core_regs_pkg::program_counter_view_offset)) begin
            next_rdata = {16'h0000, pc_view};
        end else if (hit(i_access, packet_core_regs_pkg::enabled_cycle_counter_offset)) begin
            next_rdata = cycle_count;
        end else if (hit(i_access, packet_core_regs_pkg::stall_cycle_counter_offset)) begin
            next_rdata = stall_count;
        end
    end

    // State registers
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            start_address <= packet_core_regs_pkg::start_address_reset;
            single_step <= 1'b0;
            counter_enable <= 1'b0;
            fetch_enable <= 1'b0;
            soft_reset <= 1'b1;
            pc_view <= packet_core_regs_pkg::pc_view_reset;
            cycle_count <= packet_core_regs_pkg::counter_reset;
            stall_count <= packet_core_regs_pkg::counter_reset;
            rdata <= 32'h0000_0000;
            rvalid <= 1'b0;
        end else begin
            start_address <= next_start_address;
            single_step <= next_single_step;
            counter_enable <= next_counter_enable;
            fetch_enable <= next_fetch_enable;
            soft_reset <= next_soft_reset;
            pc_view <= next_pc_view;
            cycle_count <= next_cycle_count;
            stall_count <= next_stall_count;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // Core controls; a multi-cycle instruction keeps fetch alive until done
    always_comb begin
        o_ctrl.start_address = start_address;
        o_ctrl.fetch_allow = fetch_enable || i_status.multi_busy;
        o_ctrl.core_reset = ~soft_reset;
        o_ctrl.wake = wake_req;
    end
    assign o_rdata = rdata;
    assign o_rvalid = rvalid;

    // Checks
    property p_pc_lag;
        @(posedge i_sys_clk) disable iff (!i_reset_n) 1'b1 |=> pc_view == $past(i_status.pc);
    endproperty
    a_pc_lag: assert property (p_pc_lag) else $error("pc view lag wrong");
    property p_cycle_inc;
        @(posedge i_sys_clk) disable iff (!i_reset_n) counting |=> cycle_count == $past(cycle_count) + 32'h1;
    endproperty
    a_cycle_inc: assert property (p_cycle_inc) else $error("cycle count missed");
    property p_stall_inc;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            counting && i_status.stalled |=> stall_count == $past(stall_count) + 32'h1;
    endproperty
    a_stall_inc: assert property (p_stall_inc) else $error("stall count missed");
    property p_stall_le;
        @(posedge i_sys_clk) disable iff (!i_reset_n) stall_count <= cycle_count;
    endproperty
    a_stall_le: assert property (p_stall_le) else $error("stall exceeds cycle");
    property p_hold;
        @(posedge i_sys_clk) disable iff (!i_reset_n) !counter_enable && !wr_ctrl |=> $stable(cycle_count);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved while off");
    sequence s_clear_rst;
        wr_ctrl && !i_access.wdata[0];
    endsequence
    property p_srst;
        @(posedge i_sys_clk) disable iff (!i_reset_n) s_clear_rst |=> !soft_reset ##1 soft_reset;
    endproperty
    a_srst: assert property (p_srst) else $error("soft reset not restored");
    property p_step;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            single_step && fetch_enable && i_status.instr_done && !wr_ctrl |=> !fetch_enable;
    endproperty
    a_step: assert property (p_step) else $error("step did not stop fetch");
    property p_reserved;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            rvalid && $past(hit(i_access, packet_core_regs_pkg::core_control_offset)) |->
                o_rdata[13:9] == 5'h00 && o_rdata[7:4] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");
    property p_start;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            wr_ctrl |=> o_ctrl.start_address == $past(i_access.wdata[31:16]);
    endproperty
    a_start: assert property (p_start) else $error("start address not stored");

    // Read requests in the register region, in general and at one offset
    sequence s_read_req;
        i_access.req && i_access.regs_req && !i_access.wr;
    endsequence
    sequence s_read_at(logic [7:0] off);
        hit(i_access, off) && !i_access.wr;
    endsequence

    // A read in the register region is answered one cycle later
    property p_rvalid_read;
        @(posedge i_sys_clk) disable iff (!i_reset_n) s_read_req |=> o_rvalid;
    endproperty
    a_rvalid_read: assert property (p_rvalid_read) else $error("read not answered");

    // No answer without a read request, so instruction RAM traffic stays silent here
    property p_no_rvalid;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            !(i_access.req && i_access.regs_req && !i_access.wr) |=> !o_rvalid;
    endproperty
    a_no_rvalid: assert property (p_no_rvalid) else $error("answer without read");

    // Accesses without the region request leave start address, step and counter enable alone
    property p_ro_region;
        @(posedge i_sys_clk) disable iff (!i_reset_n) i_access.req && !i_access.regs_req |=>
            $stable(start_address) && $stable(single_step) && $stable(counter_enable);
    endproperty
    a_ro_region: assert property (p_ro_region) else $error("other region wrote control");

    // Program counter word returns the registered view
    property p_pc_read;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            s_read_at(packet_core_regs_pkg::program_counter_view_offset) |=> o_rdata == {16'h0000, $past(pc_view)};
    endproperty
    a_pc_read: assert property (p_pc_read) else $error("pc view read wrong");

    // Upper half of the program counter word is reserved
    property p_pc_upper;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            s_read_at(packet_core_regs_pkg::program_counter_view_offset) |=> o_rdata[31:16] == 16'h0000;
    endproperty
    a_pc_upper: assert property (p_pc_upper) else $error("pc upper bits nonzero");

    // Cycle counter word returns the count held at the taking edge
    property p_cycle_read;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            s_read_at(packet_core_regs_pkg::enabled_cycle_counter_offset) |=> o_rdata == $past(cycle_count);
    endproperty
    a_cycle_read: assert property (p_cycle_read) else $error("cycle read wrong");

    // Stall counter word returns the count held at the taking edge
    property p_stall_read;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            s_read_at(packet_core_regs_pkg::stall_cycle_counter_offset) |=> o_rdata == $past(stall_count);
    endproperty
    a_stall_read: assert property (p_stall_read) else $error("stall read wrong");

    // A fetching cycle is never counted as a stall
    property p_no_stall_idle;
        @(posedge i_sys_clk) disable iff (!i_reset_n) counting && !i_status.stalled |=> $stable(stall_count);
    endproperty
    a_no_stall_idle: assert property (p_no_stall_idle) else $error("stall counted while fetching");

    // Stall counter stops with the cycle counter
    property p_stall_hold;
        @(posedge i_sys_clk) disable iff (!i_reset_n) !counting |=> $stable(stall_count);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("stall moved while off");

    // Counter enable follows the written bit
    property p_cen_write;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            wr_ctrl |=> counter_enable == $past(i_access.wdata[packet_core_regs_pkg::counter_enable_bit]);
    endproperty
    a_cen_write: assert property (p_cen_write) else $error("counter enable not stored");

    // Step bit follows the written bit
    property p_step_write;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            wr_ctrl |=> single_step == $past(i_access.wdata[packet_core_regs_pkg::single_step_bit]);
    endproperty
    a_step_write: assert property (p_step_write) else $error("step bit not stored");

    // Run flag in the control word reflects the core at the taking edge
    property p_run_read;
        @(posedge i_sys_clk) disable iff (!i_reset_n) s_read_at(packet_core_regs_pkg::core_control_offset) |=>
            o_rdata[packet_core_regs_pkg::running_bit] == $past(i_status.running);
    endproperty
    a_run_read: assert property (p_run_read) else $error("run flag read wrong");

    // Byte order flag in the control word reflects the core at the taking edge
    property p_big_read;
        @(posedge i_sys_clk) disable iff (!i_reset_n) s_read_at(packet_core_regs_pkg::core_control_offset) |=>
            o_rdata[packet_core_regs_pkg::big_endian_bit] == $past(i_status.big_endian);
    endproperty
    a_big_read: assert property (p_big_read) else $error("endian flag read wrong");

    // Writing zero to the sleep bit wakes the core in the same cycle
    property p_wake;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
            wr_ctrl && !i_access.wdata[packet_core_regs_pkg::sleep_bit] |-> o_ctrl.wake;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missing");

    // No wake without a control write
    property p_no_wake;
        @(posedge i_sys_clk) disable iff (!i_reset_n) !wr_ctrl |-> !o_ctrl.wake;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("spurious wake");

    // A multi-cycle instruction keeps fetch alive past a cleared enable
    property p_fetch_multi;
        @(posedge i_sys_clk) disable iff (!i_reset_n) i_status.multi_busy |-> o_ctrl.fetch_allow;
    endproperty
    a_fetch_multi: assert property (p_fetch_multi) else $error("multi-cycle cut short");

    // With the enable clear and nothing in flight the core halts at once
    property p_fetch_off;
        @(posedge i_sys_clk) disable iff (!i_reset_n) !fetch_enable && !i_status.multi_busy |-> !o_ctrl.fetch_allow;
    endproperty
    a_fetch_off: assert property (p_fetch_off) else $error("fetch without enable");

    // Soft reset bit returns to one whenever no write clears it
    property p_srst_idle;
        @(posedge i_sys_clk) disable iff (!i_reset_n) !wr_ctrl |=> soft_reset;
    endproperty
    a_srst_idle: assert property (p_srst_idle) else $error("soft reset stuck");
endmodule : packet_core_ctrl_status_regs
`default_nettype wire

// >>> core/packet_core_regs_pkg.sv
// Package with register map, field positions and bus types for the packet core register bank
package packet_core_regs_pkg;
    localparam logic [7:0] core_control_offset = 8'h00;
    localparam logic [7:0] program_counter_view_offset = 8'h04;
    localparam logic [7:0] enabled_cycle_counter_offset = 8'h0c;
    localparam logic [7:0] stall_cycle_counter_offset = 8'h10;
    localparam int start_address_lsb = 16;
    localparam int running_bit = 15;
    localparam int big_endian_bit = 14;
    localparam int single_step_bit = 8;
    localparam int counter_enable_bit = 3;
    localparam int sleep_bit = 2;
    localparam int fetch_enable_bit = 1;
    localparam int soft_reset_bit = 0;
    localparam logic [15:0] start_address_reset = 16'h0000;
    localparam logic [31:0] counter_reset = 32'h0000_0000;
    localparam logic [15:0] pc_view_reset = 16'h0000;

    // Host access on the instruction-RAM slave port
    typedef struct packed {
        logic req;
        logic regs_req;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } reg_access_t;

    // Status from the execution core
    typedef struct packed {
        logic [15:0] pc;
        logic running;
        logic big_endian;
        logic asleep;
        logic stalled;
        logic instr_done;
        logic multi_busy;
    } core_status_t;

    // Controls to the execution core
    typedef struct packed {
        logic [15:0] start_address;
        logic fetch_allow;
        logic core_reset;
        logic wake;
    } core_ctrl_t;
endpackage : packet_core_regs_pkg

// >>> dv/packet_core_ctrl_status_regs_tb_top.sv
// Self-checking bench for the packet core register bank
`timescale 1ns/1ps
`default_nettype none
module packet_core_ctrl_status_regs_tb_top;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    packet_core_regs_pkg::reg_access_t acc = '0;
    packet_core_regs_pkg::core_status_t st;
    packet_core_regs_pkg::core_ctrl_t ctl;
    logic [31:0] rdata, rd, a, b, c, d, seed = 32'h0000_0034;
    logic rvalid, wk, stall = 1'b0, big = 1'b0, sleep_flag = 1'b0, multi = 1'b0;
    logic [15:0] pc_last, pexp, sa;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    packet_core_ctrl_status_regs dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_access(acc),
        .i_status(st), .o_rdata(rdata), .o_rvalid(rvalid), .o_ctrl(ctl));
    packet_core_model core (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_ctrl(ctl),
        .i_stall(stall), .i_big(big), .i_asleep(sleep_flag), .i_multi(multi), .o_status(st));
    always #50 i_sys_clk = ~i_sys_clk;
    // Track the live counter and cut a hang short
    always @(posedge i_sys_clk) begin
        pc_last <= st.pc;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Expected control word built from the field layout
    function automatic logic [31:0] cw(input logic run, input logic stp, input logic cen, input logic fen);
        return {sa, run, big, 5'h00, stp, 4'h0, cen, sleep_flag, fen, 1'b1};
    endfunction : cw
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // One access: held from a falling edge through the taking edge, answer sampled at the next falling edge
    task automatic bus(input logic wr, input logic sel, input logic [7:0] ad, input logic [31:0] wd,
        output logic [31:0] r);
        @(negedge i_sys_clk);
        acc = '{req: 1'b1, regs_req: sel, wr: wr, addr: ad, wdata: wd};
        #1 wk = ctl.wake;
        @(posedge i_sys_clk);
        pexp = pc_last;
        @(negedge i_sys_clk);
        acc.req = 1'b0;
        cmp({31'h0, rvalid}, {31'h0, !wr && sel});
        r = rdata;
    endtask : bus
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    initial begin
        sa = 16'h0000;
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        i_reset_n = 1'b1;
        bus(1'b0, 1'b1, 8'h00, 32'h0, rd);
        cmp(rd, cw(1'b0, 1'b0, 1'b0, 1'b0));
        bus(1'b0, 1'b1, 8'h0c, 32'h0, rd);
        cmp(rd, 32'h0000_0000);
        $display("test reset_image done");
        // Random start address and status with counters running; stall held over each window
        for (int i = 0; i < 8; i++) begin
            a = xs();
            {sa, big, sleep_flag, stall} = {a[31:16], a[0], a[1], a[2]};
            bus(1'b1, 1'b1, 8'h00, {a[31:16], 16'hfeff}, rd);
            cmp({31'h0, wk}, 32'h0);
            cmp({16'h0, ctl.start_address}, {16'h0, sa});
            bus(1'b0, 1'b1, 8'h00, 32'h0, rd);
            cmp(rd, cw(1'b1, 1'b0, 1'b1, 1'b1));
            bus(1'b0, 1'b1, 8'h0c, 32'h0, b);
            bus(1'b0, 1'b1, 8'h10, 32'h0, c);
            repeat (a[5:3]) @(negedge i_sys_clk);
            bus(1'b0, 1'b1, 8'h0c, 32'h0, d);
            bus(1'b0, 1'b1, 8'h10, 32'h0, rd);
            cmp(d - b, 32'd4 + a[5:3]);
            cmp(rd - c, stall ? 32'd4 + a[5:3] : 32'd0);
            cmp({31'h0, c <= b + 32'd2}, 32'h1);
            bus(1'b0, 1'b1, 8'h04, 32'h0, rd);
            cmp(rd, {16'h0, pexp});
        end
        $display("test random_control done");
        // Counters held, read-only words and the other region left alone
        bus(1'b1, 1'b1, 8'h00, {sa, 16'h0007}, rd);
        bus(1'b0, 1'b1, 8'h0c, 32'h0, b);
        bus(1'b1, 1'b1, 8'h0c, 32'hffff_ffff, rd);
        bus(1'b1, 1'b0, 8'h00, 32'h1234_feff, rd);
        bus(1'b0, 1'b1, 8'h0c, 32'h0, d);
        cmp(d, b);
        bus(1'b0, 1'b1, 8'h08, 32'h0, rd);
        cmp(rd, 32'h0000_0000);
        bus(1'b0, 1'b1, 8'h00, 32'h0, rd);
        cmp(rd, cw(1'b1, 1'b0, 1'b0, 1'b1));
        $display("test protection done");
        // Soft reset pulse, wake pulse, then a single step that halts the core
        bus(1'b1, 1'b1, 8'h00, {sa, 16'h0006}, rd);
        cmp({31'h0, ctl.core_reset}, 32'h1);
        @(negedge i_sys_clk);
        cmp({31'h0, ctl.core_reset}, 32'h0);
        bus(1'b0, 1'b1, 8'h00, 32'h0, rd);
        cmp(rd, cw(1'b1, 1'b0, 1'b0, 1'b1));
        bus(1'b1, 1'b1, 8'h00, {sa, 16'h0002}, rd);
        cmp({31'h0, wk}, 32'h1);
        stall = 1'b0;
        bus(1'b1, 1'b1, 8'h00, {sa, 16'h0106}, rd);
        repeat (4) @(negedge i_sys_clk);
        cmp({31'h0, ctl.fetch_allow}, 32'h0);
        bus(1'b0, 1'b1, 8'h00, 32'h0, rd);
        cmp(rd, cw(1'b0, 1'b1, 1'b0, 1'b0));
        // Multi-cycle instruction in flight holds fetch after the enable is cleared
        multi = 1'b1;
        bus(1'b1, 1'b1, 8'h00, {sa, 16'h0005}, rd);
        cmp({31'h0, ctl.fetch_allow}, 32'h1);
        multi = 1'b0;
        @(negedge i_sys_clk);
        cmp({31'h0, ctl.fetch_allow}, 32'h0);
        $display("test step_and_reset done");
        close_out();
    end
endmodule : packet_core_ctrl_status_regs_tb_top
`default_nettype wire

// >>> dv/packet_core_model.sv
// Behavioural execution core that feeds live status to the register bank
`timescale 1ns/1ps
`default_nettype none
module packet_core_model (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire packet_core_regs_pkg::core_ctrl_t i_ctrl,
    input wire logic i_stall,
    input wire logic i_big,
    input wire logic i_asleep,
    input wire logic i_multi,
    output var packet_core_regs_pkg::core_status_t o_status
);
    logic [15:0] pc;
    logic go;
    // One instruction retires in each unstalled cycle while fetch is allowed
    assign go = i_ctrl.fetch_allow & ~i_stall;
    // Restart from the programmed start address on either reset
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n || i_ctrl.core_reset) begin
            pc <= i_ctrl.start_address;
        end else if (go) begin
            pc <= pc + 16'h0001;
        end
    end
    // Run state follows fetch at once, so a polling agent sees the halt without delay
    assign o_status = '{pc: pc, running: i_ctrl.fetch_allow, big_endian: i_big, asleep: i_asleep,
        stalled: i_ctrl.fetch_allow & i_stall, instr_done: go, multi_busy: i_multi};
endmodule : packet_core_model
`default_nettype wire
